/* File: design/bpc_config_regs.v */
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_regs.vh"
// Summary of operation
// (R01) hard reg bit 7 is read-only bus park disable from park strap
// (R02) park strap is captured at reset release and then held
// (R03) a captured flag is 1 when its active-low strap was asserted
// (R04) hard reg bits 13:12 hold read-only agent id captured at release
// (R05) agent id is encoded from the bus request straps: the index of the lowest asserted strap
// (R06) soft power-on register is readable and writable by software
// (R07) soft bit 0 enables request/snoop count driving, default 0
// (R08) soft bit 1 set disables data parity checking
// (R09) soft bits 2 and 3 disable response and address checks, default 1
// (R10) soft bit 4 set stops machine-check driving for initiator requests
// (R11) soft bit 5 set stops machine-check driving for internal errors
// (R12) soft bit 6 set disables bus-init driver, default set
// (R13) frequency register layout chosen by processor model value
// (R14) model 2 or above: frequency bits 15:0 reserved
// (R15) frequency register reports current frequency status
// (R16) hard register at 0x2a, strap fields read-only
// (R17) reserved bits read zero, writes ignored
// (R18) soft register returns defaults after reset
module bpc_config_regs #(
  parameter MODEL = 4'h2  // processor model value
) (
  input  wire                     sys_clk,        // 100 MHz clock
  input  wire                     rst_n,          // synchronous reset, active low
  input  wire [`BPC_ADDR_W-1:0]   reg_addr,       // register index
  input  wire [`BPC_DATA_W-1:0]   reg_wdata,      // write data
  input  wire                     reg_wr,         // write strobe
  input  wire                     reg_rd,         // read strobe
  output reg  [`BPC_DATA_W-1:0]   reg_rdata,      // read data, cycle after strobe
  input  wire                     bus_park_strap_pin,      // active low
  input  wire [3:0]               bus_request_strap_pins,  // active low
  input  wire [`BPC_FREQ_STAT_W-1:0] freq_status, // live frequency status
  output reg                      rcnt_drive_en,  // request/snoop count drive
  output reg                      data_par_chk_en,    // data parity check enable
  output reg                      resp_chk_en,    // response error check enable
  output reg                      addr_chk_en,    // address error check enable
  output reg                      mce_init_drv_en,    // machine check, initiator
  output reg                      mce_int_drv_en, // machine check, internal
  output reg                      bus_init_drv_en // bus-init driver enable
);
  wire [4:0]             flags;     // {request straps, park}
  reg  [`BPC_SOFT_W-1:0] soft_reg;  // soft power-on bits
  reg  [`BPC_SOFT_W-1:0] soft_next;
  reg  [`BPC_DATA_W-1:0] rd_next;
  wire [1:0]             agent_id;

  bpc_strap_latch #(.W(5)) u_strap (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .strap_n ({bus_request_strap_pins, bus_park_strap_pin}),  // see (R02)
    .flags   (flags)                                          // see (R03)
  );

  // agent id from request straps: lowest-asserted strap picks the id
  assign agent_id = flags[1] ? 2'h0 :   // see (R05)
                    flags[2] ? 2'h1 :
                    flags[3] ? 2'h2 :
                    flags[4] ? 2'h3 : 2'h0;

  // soft register write, only implemented bits kept
  always @* begin
    soft_next = soft_reg;
    if (reg_wr && reg_addr == `BPC_SOFT_ADDR)  // see (R06)
      soft_next = reg_wdata[`BPC_SOFT_W-1:0];  // see (R17)
  end

  // read mux
  always @* begin
    rd_next = {`BPC_DATA_W{1'b0}};  // see (R17)
    case (reg_addr)
      `BPC_HARD_ADDR: begin  // see (R16)
        rd_next[`BPC_HARD_PARK_BIT] = flags[0];  // see (R01)
        rd_next[`BPC_HARD_AGENT_HI:`BPC_HARD_AGENT_LO] = agent_id;  // see (R04)
      end
      `BPC_SOFT_ADDR: begin
        rd_next[`BPC_SOFT_W-1:0] = soft_reg;
      end
      `BPC_FREQ_ADDR: begin
        if (MODEL >= `BPC_FREQ_MODEL_MIN) begin  // see (R13)
          // low half reserved, status above it  see (R14)
          rd_next[`BPC_FREQ_STAT_LO+`BPC_FREQ_STAT_W-1:`BPC_FREQ_STAT_LO] =
            freq_status;  // see (R15)
        end else begin
          rd_next[`BPC_FREQ_STAT_W-1:0] = freq_status;
        end
      end
      default: rd_next = {`BPC_DATA_W{1'b0}};
    endcase
    if (!reg_rd)
      rd_next = {`BPC_DATA_W{1'b0}};
  end

  // registers and decoded enables
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      soft_reg        <= `BPC_SOFT_RESET;  // see (R18)
      reg_rdata       <= {`BPC_DATA_W{1'b0}};
      rcnt_drive_en   <= 1'b0;
      data_par_chk_en <= 1'b1;
      resp_chk_en     <= 1'b0;
      addr_chk_en     <= 1'b0;
      mce_init_drv_en <= 1'b0;
      mce_int_drv_en  <= 1'b0;
      bus_init_drv_en <= 1'b0;
    end else begin
      soft_reg        <= soft_next;
      reg_rdata       <= rd_next;
      rcnt_drive_en   <= soft_next[`BPC_SOFT_RCNT_BIT];    // see (R07)
      data_par_chk_en <= ~soft_next[`BPC_SOFT_DPAR_BIT];   // see (R08)
      resp_chk_en     <= ~soft_next[`BPC_SOFT_RESP_BIT];   // see (R09)
      addr_chk_en     <= ~soft_next[`BPC_SOFT_ADDR_BIT];   // see (R09)
      mce_init_drv_en <= ~soft_next[`BPC_SOFT_IMCE_BIT];   // see (R10)
      mce_int_drv_en  <= ~soft_next[`BPC_SOFT_NMCE_BIT];   // see (R11)
      bus_init_drv_en <= ~soft_next[`BPC_SOFT_BUS_INIT_PIN_BIT];  // see (R12)
    end
  end
endmodule // bpc_config_regs
`default_nettype wire

/* File: design/bpc_regs.vh */
`ifndef BPC_REGS_VH
`define BPC_REGS_VH
// register indices (byte-free plain port addressing)
`define BPC_ADDR_W          8
`define BPC_HARD_ADDR       8'h2a
`define BPC_SOFT_ADDR       8'h2b
`define BPC_FREQ_ADDR       8'h2c
`define BPC_DATA_W          64
// hard power-on fields
`define BPC_HARD_PARK_BIT   7
`define BPC_HARD_AGENT_LO   12
`define BPC_HARD_AGENT_HI   13
// soft power-on fields
`define BPC_SOFT_W          7
`define BPC_SOFT_RCNT_BIT   0
`define BPC_SOFT_DPAR_BIT   1
`define BPC_SOFT_RESP_BIT   2
`define BPC_SOFT_ADDR_BIT   3
`define BPC_SOFT_IMCE_BIT   4
`define BPC_SOFT_NMCE_BIT   5
`define BPC_SOFT_BUS_INIT_PIN_BIT  6
`define BPC_SOFT_RESET      7'h7c
// frequency config fields
`define BPC_FREQ_RSV_HI     15
`define BPC_FREQ_STAT_LO    16
`define BPC_FREQ_STAT_W     16
`define BPC_FREQ_MODEL_MIN  4'h2
`endif

/* File: design/bpc_strap_latch.v */
`timescale 1ns/1ps
`default_nettype none
// captures active-low straps on the cycle reset is released
module bpc_strap_latch #(
  parameter W = 5
) (
  input  wire         sys_clk,   // system clock
  input  wire         rst_n,     // synchronous reset, active low
  input  wire [W-1:0] strap_n,   // active-low strap pins
  output reg  [W-1:0] flags      // captured flags, 1 = strap asserted
);
  reg rst_seen_reg; // high once the first cycle out of reset has passed

  // sample straps only on the first edge after release, then hold
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_seen_reg <= 1'b0;
      flags        <= {W{1'b0}};
    end else if (!rst_seen_reg) begin
      rst_seen_reg <= 1'b1;
      flags        <= ~strap_n;
    end
  end
endmodule // bpc_strap_latch
`default_nettype wire

/* File: dv/bpc_bus_agent.sv */
`timescale 1ns/1ps
`default_nettype none
// another agent's strapping
module bpc_bus_agent (
  input  wire logic       park_dis,              // park off
  input  wire logic [1:0] agent_id,              // id
  output wire logic       bus_park_strap_pin,    // low on
  output wire logic [3:0] bus_request_strap_pins // low on
);
  // only the request strap naming the agent is low
  assign bus_park_strap_pin = ~park_dis;
  assign bus_request_strap_pins = ~(4'h1 << agent_id);
endmodule // bpc_bus_agent
`default_nettype wire

/* File: dv/bpc_config_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module bpc_chk (
  input wire logic        sys_clk,         // clk
  input wire logic        rst_n,           // rst
  input wire logic [7:0]  reg_addr,        // idx
  input wire logic [63:0] reg_wdata,       // wd
  input wire logic        reg_wr,          // wr
  input wire logic        reg_rd,          // rd
  input wire logic [63:0] reg_rdata,       // rd
  input wire logic        rcnt_drive_en,   // en
  input wire logic        data_par_chk_en, // en
  input wire logic        resp_chk_en,     // en
  input wire logic        addr_chk_en,     // en
  input wire logic        mce_init_drv_en, // en
  input wire logic        mce_int_drv_en,  // en
  input wire logic        bus_init_drv_en  // en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic       sq = 1'b0;
  logic [6:0] wq = 7'h0;
  // soft write taken at the last edge
  always @(posedge sys_clk) begin
    sq <= reg_wr && reg_addr == 8'h2b;
    wq <= reg_wdata[6:0];
  end
  property p_rcnt; sq |-> rcnt_drive_en == wq[0]; endproperty
  a_rcnt: assert property (p_rcnt) else $error("rcnt");
  property p_dpar; sq |-> data_par_chk_en != wq[1]; endproperty
  a_dpar: assert property (p_dpar) else $error("dpar");
  property p_resp; sq |-> resp_chk_en != wq[2]; endproperty
  a_resp: assert property (p_resp) else $error("resp");
  property p_addr; sq |-> addr_chk_en != wq[3]; endproperty
  a_addr: assert property (p_addr) else $error("addr");
  property p_mcei; sq |-> mce_init_drv_en != wq[4]; endproperty
  a_mcei: assert property (p_mcei) else $error("mcei");
  property p_mcen; sq |-> mce_int_drv_en != wq[5]; endproperty
  a_mcen: assert property (p_mcen) else $error("mcen");
  property p_bini; sq |-> bus_init_drv_en != wq[6]; endproperty
  a_bini: assert property (p_bini) else $error("bini");
  property p_hard; reg_rd && reg_addr == 8'h2a |=> reg_rdata[63:14] == 0 && reg_rdata[11:8] == 0; endproperty
  a_hard: assert property (p_hard) else $error("hard");
endmodule // bpc_chk
bind bpc_config_regs bpc_chk i_chk (.*);
`default_nettype wire

/* File: dv/bus_power_on_config_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_power_on_config_regs_tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, park_dis = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [63:0] reg_wdata = 64'h0;
  logic [15:0] freq_status = 16'hbeef;
  logic [1:0] agent_id = 2'h2;
  wire logic [63:0] reg_rdata;
  wire logic [3:0] bus_request_strap_pins;
  wire logic bus_park_strap_pin, rcnt_drive_en, data_par_chk_en, resp_chk_en, addr_chk_en;
  wire logic mce_init_drv_en, mce_int_drv_en, bus_init_drv_en;
  wire logic [6:0] en = {bus_init_drv_en, mce_int_drv_en, mce_init_drv_en, addr_chk_en,
                         resp_chk_en, data_par_chk_en, rcnt_drive_en};
  int mismatches = 0, compares = 0;
  always #5 sys_clk = ~sys_clk;
  bpc_bus_agent i_agent (.*);
  bpc_config_regs i_dut (.*);
  task automatic check(string s, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [63:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [63:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check("rdata", e, reg_rdata);
  endtask
  task automatic conclude();
    if (compares > 0 && mismatches == 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // straps change after capture; a second reset recaptures them
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    park_dis <= 1'b0;
    agent_id <= 2'h1;
    rd(8'h2a, 64'h2080);
    rd(8'h2b, 64'h7c);
    wr(8'h2a, '1);
    wr(8'h2c, '1);
    rd(8'h2a, 64'h2080);
    rd(8'h2c, 64'hbeef_0000);
    rd(8'h30, 64'h0);
    for (int i = 0; i < 7; i++) begin
      wr(8'h2b, 64'hff00_0000_0000_0000 | (64'h1 << i));
      check("en", 64'(7'h7e ^ 7'(1 << i)), 64'(en));
      rd(8'h2b, 64'h1 << i);
    end
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h2b, 64'h7c);
    rd(8'h2a, 64'h1000);
    conclude();
  end
endmodule // bus_power_on_config_regs_tb_top
`default_nettype wire
